//--- core/flow_pulse_pkg.sv
// constants and types shared by the flow pulse and test control logic
package flow_pulse_pkg;

    // ------------------------------------------------------------------
    // clock rate
    // ------------------------------------------------------------------
    localparam int CLK_KHZ     = 50_000;
    localparam int CLK_PER_US  = 50;

    // ------------------------------------------------------------------
    // times in their own units
    // ------------------------------------------------------------------
    localparam int EMIT_INTERVAL_MS = 1000;   // one emission interval
    localparam int PULSE_WIDTH_US   = 3000;   // inside the 2..5 ms window
    localparam int BURST_PAUSE_MS   = 30;     // pause between bursts
    localparam int MEAS_PERIOD_MS   = 250;    // normal measuring routine
    localparam int TEST_SPEEDUP     = 4;      // test routine is a quarter
    localparam int GAP_SLOW_US      = 40000;
    localparam int GAP_MID_US       = 20000;
    localparam int GAP_FAST_US      = 8000;
    localparam int GAP_MAX_US       = 2000;

    // ------------------------------------------------------------------
    // derived cycle counts
    // ------------------------------------------------------------------
    localparam int EMIT_CYC      = EMIT_INTERVAL_MS * CLK_KHZ;
    localparam int PULSE_CYC     = PULSE_WIDTH_US * CLK_PER_US;
    localparam int PAUSE_CYC     = BURST_PAUSE_MS * CLK_KHZ;
    localparam int MEAS_CYC      = MEAS_PERIOD_MS * CLK_KHZ;
    localparam int TEST_MEAS_CYC = MEAS_CYC / TEST_SPEEDUP;
    localparam int GAP_SLOW_CYC  = GAP_SLOW_US * CLK_PER_US;
    localparam int GAP_MID_CYC   = GAP_MID_US * CLK_PER_US;
    localparam int GAP_FAST_CYC  = GAP_FAST_US * CLK_PER_US;
    localparam int GAP_MAX_CYC   = GAP_MAX_US * CLK_PER_US;

    // ------------------------------------------------------------------
    // emission shaping and averaging
    // ------------------------------------------------------------------
    localparam int MAX_PULSES   = 128;   // cap of 128 Hz
    localparam int BURST_LEN    = 16;
    localparam int N_SLOW       = 16;
    localparam int N_MID        = 32;
    localparam int N_FAST       = 64;
    localparam int AVG_DEPTH    = 8;     // seconds averaged, bounds the tail
    localparam int AVG_SHIFT    = 3;
    localparam int VOL_FRAC     = 8;     // volume is pulses in Q.8
    localparam int SYNC_SETTLE  = 2;     // cycle at which the strap is read

    typedef enum logic [3:0] {
        EM_IDLE  = 4'h1,
        EM_HIGH  = 4'h2,
        EM_GAP   = 4'h4,
        EM_PAUSE = 4'h8
    } emit_state_type;

endpackage

//--- core/flow_pulse_test_control.sv
// pulse emission, averaging and externally timed test accumulation
//
// Behaviour
// - pulses go out in one-second intervals, a new group at each interval start
// - pulse count for the next interval is recomputed every second
// - pulses sent in bursts, 2..5 ms high, gap set by pulse frequency
// - about 30 ms pause between consecutive bursts
// - pulse count comes from an average of many flow measurements
// - averaging gives a start transient and at most 8 s trailing pulses
// - test mode runs the measuring routine four times faster
// - pin held low at power-up selects test mode about one second later
// - test mode holds until power is removed
// - in test mode, pin low accumulates volume, release stops it
// - accumulation uses the same measurements as pulse emission
// - first volume counted only for the share after the start edge
// - at stop, last volume share since the last measurement is added
// - accumulated volume is offered for reading after the window closes
// - releasing the pin at test end stops pulse emission for the rest of that interval
// - no pulses below minimum cut-off or for reverse flow
// - pulse rate capped at 128 Hz
module flow_pulse_test_control #(
    parameter int EMIT_CYC      = flow_pulse_pkg::EMIT_CYC,
    parameter int PULSE_CYC     = flow_pulse_pkg::PULSE_CYC,
    parameter int PAUSE_CYC     = flow_pulse_pkg::PAUSE_CYC,
    parameter int MEAS_CYC      = flow_pulse_pkg::MEAS_CYC,
    parameter int TEST_MEAS_CYC = flow_pulse_pkg::TEST_MEAS_CYC,
    parameter int GAP_SLOW_CYC  = flow_pulse_pkg::GAP_SLOW_CYC,
    parameter int GAP_MID_CYC   = flow_pulse_pkg::GAP_MID_CYC,
    parameter int GAP_FAST_CYC  = flow_pulse_pkg::GAP_FAST_CYC,
    parameter int GAP_MAX_CYC   = flow_pulse_pkg::GAP_MAX_CYC,
    parameter int CUTOFF        = 1,     // minimum average, Q.8 pulses/s
    parameter int VW            = 24,
    parameter int AW            = 32,
    parameter int CW            = 26
) (
    input  wire logic                 clk_i,
    input  wire logic                 reset_n_i,
    input  wire logic                 test_ctl_n_i,
    input  wire logic signed [VW-1:0] meas_volume_i,
    output logic                      meas_strobe_o,
    output logic                      pulse_o,
    output logic                      test_mode_o,
    output logic                      accum_active_o,
    output logic                      accum_ready_o,
    output logic signed [AW-1:0]      accum_volume_o
);

    localparam int SW = VW + 6;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                               sync1;
        logic                               sync2;
        logic                               pin_prev;
        logic [CW-1:0]                      sec_cnt;
        logic [CW-1:0]                      meas_cnt;
        logic [CW-1:0]                      tmr;
        logic [CW-1:0]                      start_excess_time;
        logic [CW-1:0]                      hi_len;
        logic                               booting;
        logic                               strap_low;
        logic                               test_mode;
        logic                               armed;
        logic                               active;
        logic                               first_pending;
        logic                               acc_ready;
        logic                               pulse;
        logic signed [VW-1:0]               last_vol;
        logic signed [SW-1:0]               sec_sum;
        logic [flow_pulse_pkg::AVG_DEPTH-1:0][SW-1:0] hist;
        logic signed [AW-1:0]               acc;
        logic signed [AW-1:0]               acc_out;
        logic [7:0]                         pulses_left;
        logic [7:0]                         emit_n;
        logic [4:0]                         burst_cnt;
        flow_pulse_pkg::emit_state_type     em;
    } state_type;

    state_type s_ff;
    state_type nxt_s;

    logic                 start_edge;
    logic                 stop_edge;
    logic                 meas_tick;
    logic                 sec_tick;
    logic [CW-1:0]        period;
    logic [7:0]           avg_cnt;
    logic signed [SW-1:0] cur_sum;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // share of a volume over a part of one test measuring period
    function automatic logic signed [AW-1:0] share(input logic signed [VW-1:0] vol,
                                                   input logic [CW-1:0] cyc);
        logic signed [VW+CW:0] prod;
        prod = vol * $signed({1'b0, cyc});
        return AW'(prod / TEST_MEAS_CYC);
    endfunction

    // average over the history window, clipped to cut-off and cap
    function automatic logic [7:0] avg_pulses(
            input logic [flow_pulse_pkg::AVG_DEPTH-1:0][SW-1:0] h);
        logic signed [SW+3:0] sum;
        logic signed [SW+3:0] avg;
        sum = '0;
        for (int i = 0; i < flow_pulse_pkg::AVG_DEPTH; i++) begin
            sum = sum + (SW+4)'($signed(h[i]));
        end
        avg = sum >>> flow_pulse_pkg::AVG_SHIFT;
        if (avg < (SW+4)'(CUTOFF)) begin
            return 8'h00;
        end else if ((avg >>> flow_pulse_pkg::VOL_FRAC) >=
                     (SW+4)'(flow_pulse_pkg::MAX_PULSES)) begin
            return 8'(flow_pulse_pkg::MAX_PULSES);
        end
        return 8'(avg >>> flow_pulse_pkg::VOL_FRAC);
    endfunction

    // low rates spread pulses wide, high rates pack them tight
    function automatic logic [CW-1:0] gap_cycles(input logic [7:0] n);
        if (n <= 8'(flow_pulse_pkg::N_SLOW)) begin
            return CW'(GAP_SLOW_CYC);
        end else if (n <= 8'(flow_pulse_pkg::N_MID)) begin
            return CW'(GAP_MID_CYC);
        end else if (n <= 8'(flow_pulse_pkg::N_FAST)) begin
            return CW'(GAP_FAST_CYC);
        end
        return CW'(GAP_MAX_CYC);
    endfunction

    // ------------------------------------------------------------------
    // events
    // ------------------------------------------------------------------
    // edges only from the second synchroniser stage onward
    assign start_edge = s_ff.armed && !s_ff.active && s_ff.pin_prev && !s_ff.sync2;
    assign stop_edge  = s_ff.active && !s_ff.pin_prev && s_ff.sync2;
    assign period     = s_ff.test_mode ? CW'(TEST_MEAS_CYC) : CW'(MEAS_CYC);
    assign meas_tick  = (s_ff.meas_cnt >= period - CW'(1));  // no stall at a period switch
    assign sec_tick   = (s_ff.sec_cnt == CW'(EMIT_CYC - 1));
    assign cur_sum    = s_ff.sec_sum + (meas_tick ? SW'(meas_volume_i) : SW'(0));
    assign avg_cnt    = avg_pulses({s_ff.hist[flow_pulse_pkg::AVG_DEPTH-2:0], cur_sum});

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        // two-stage synchroniser on the control pin
        nxt_s.sync1    = test_ctl_n_i;
        nxt_s.sync2    = s_ff.sync1;
        nxt_s.pin_prev = s_ff.sync2;
        nxt_s.hi_len   = s_ff.pulse ? s_ff.hi_len + CW'(1) : CW'(0);
        nxt_s.sec_cnt  = sec_tick ? CW'(0) : s_ff.sec_cnt + CW'(1);
        nxt_s.meas_cnt = meas_tick ? CW'(0) : s_ff.meas_cnt + CW'(1);

        // strap is caught once the synchroniser has settled
        if (s_ff.booting && s_ff.sec_cnt == CW'(flow_pulse_pkg::SYNC_SETTLE)) begin
            nxt_s.strap_low = !s_ff.sync2;
        end
        if (sec_tick && s_ff.booting) begin
            nxt_s.booting   = 1'b0;
            nxt_s.test_mode = s_ff.strap_low;
        end
        // a start only counts after the strap level has been released
        if (s_ff.test_mode && !s_ff.armed && s_ff.sync2) begin
            nxt_s.armed = 1'b1;
        end

        // measurement arrival feeds both averaging and accumulation
        if (meas_tick) begin
            nxt_s.last_vol = meas_volume_i;
            if (s_ff.active) begin
                if (s_ff.first_pending) begin
                    nxt_s.acc = s_ff.acc + share(meas_volume_i,
                                CW'(TEST_MEAS_CYC) - s_ff.start_excess_time);
                    nxt_s.first_pending = 1'b0;
                end else begin
                    nxt_s.acc = s_ff.acc + AW'(meas_volume_i);
                end
            end
        end
        nxt_s.sec_sum = cur_sum;

        // pulse emitter
        case (s_ff.em)
            flow_pulse_pkg::EM_HIGH: begin
                if (s_ff.tmr == CW'(PULSE_CYC - 1)) begin
                    nxt_s.pulse       = 1'b0;
                    nxt_s.tmr         = '0;
                    nxt_s.pulses_left = s_ff.pulses_left - 8'h01;
                    nxt_s.burst_cnt   = s_ff.burst_cnt + 5'h01;
                    if (s_ff.pulses_left == 8'h01) begin
                        nxt_s.em = flow_pulse_pkg::EM_IDLE;
                    end else if (s_ff.burst_cnt == 5'(flow_pulse_pkg::BURST_LEN - 1)) begin
                        nxt_s.em        = flow_pulse_pkg::EM_PAUSE;
                        nxt_s.burst_cnt = '0;
                    end else begin
                        nxt_s.em = flow_pulse_pkg::EM_GAP;
                    end
                end else begin
                    nxt_s.tmr = s_ff.tmr + CW'(1);
                end
            end
            flow_pulse_pkg::EM_GAP: begin
                if (s_ff.tmr == gap_cycles(s_ff.emit_n) - CW'(1)) begin
                    nxt_s.em    = flow_pulse_pkg::EM_HIGH;
                    nxt_s.pulse = 1'b1;
                    nxt_s.tmr   = '0;
                end else begin
                    nxt_s.tmr = s_ff.tmr + CW'(1);
                end
            end
            flow_pulse_pkg::EM_PAUSE: begin
                if (s_ff.tmr == CW'(PAUSE_CYC - 1)) begin
                    nxt_s.em    = flow_pulse_pkg::EM_HIGH;
                    nxt_s.pulse = 1'b1;
                    nxt_s.tmr   = '0;
                end else begin
                    nxt_s.tmr = s_ff.tmr + CW'(1);
                end
            end
            flow_pulse_pkg::EM_IDLE: begin
                nxt_s.pulse = 1'b0;
            end
            default: begin
                nxt_s.em    = flow_pulse_pkg::EM_IDLE;
                nxt_s.pulse = 1'b0;
            end
        endcase

        // interval start: shift history, recompute, restart the group
        if (sec_tick) begin
            nxt_s.hist    = {s_ff.hist[flow_pulse_pkg::AVG_DEPTH-2:0], cur_sum};
            nxt_s.sec_sum = '0;
            nxt_s.emit_n      = avg_cnt;
            nxt_s.pulses_left = avg_cnt;
            nxt_s.burst_cnt   = '0;
            nxt_s.tmr         = '0;
            nxt_s.pulse       = (avg_cnt != 8'h00);
            nxt_s.em          = (avg_cnt != 8'h00) ? flow_pulse_pkg::EM_HIGH
                                                   : flow_pulse_pkg::EM_IDLE;
        end

        // test window open
        if (start_edge) begin
            nxt_s.active        = 1'b1;
            nxt_s.first_pending = 1'b1;
            nxt_s.acc_ready     = 1'b0;
            nxt_s.acc           = '0;
            nxt_s.start_excess_time = meas_tick ? CW'(0) : s_ff.meas_cnt;
        end
        // test window close: correction, result, emission halted
        if (stop_edge) begin
            nxt_s.active  = 1'b0;
            nxt_s.acc_ready = 1'b1;
            nxt_s.acc_out = meas_tick ? nxt_s.acc
                          : s_ff.acc + share(s_ff.last_vol, s_ff.meas_cnt -
                            (s_ff.first_pending ? s_ff.start_excess_time : CW'(0)));
            nxt_s.em          = flow_pulse_pkg::EM_IDLE;
            nxt_s.pulse       = 1'b0;
            nxt_s.pulses_left = '0;
        end
    end

    // ------------------------------------------------------------------
    // registers; test mode only leaves by a fresh power-on reset
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_ff          <= '0;
            s_ff.sync1    <= 1'b1;
            s_ff.sync2    <= 1'b1;
            s_ff.pin_prev <= 1'b1;
            s_ff.booting  <= 1'b1;
            s_ff.em       <= flow_pulse_pkg::EM_IDLE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign meas_strobe_o  = meas_tick;
    assign pulse_o        = s_ff.pulse;
    assign test_mode_o    = s_ff.test_mode;
    assign accum_active_o = s_ff.active;
    assign accum_ready_o  = s_ff.acc_ready;
    assign accum_volume_o = s_ff.acc_out;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_PULSE_WIDTH: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ($fell(pulse_o) && !$past(stop_edge) && !$past(sec_tick)) |->
            s_ff.hi_len == CW'(PULSE_CYC))
        else $error("pulse high time wrong");
    AST_TEST_STICKY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        test_mode_o |=> test_mode_o)
        else $error("test mode left");
    AST_PULSE_CAP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_ff.pulses_left <= 8'(flow_pulse_pkg::MAX_PULSES))
        else $error("pulse count above cap");
    AST_STOP_SILENCE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (stop_edge && !sec_tick) |=> (!pulse_o && s_ff.pulses_left == 8'h00)
            ##1 (!pulse_o || $past(sec_tick)))
        else $error("pulses after test stop");
    AST_RESULT_READY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        stop_edge |=> accum_ready_o && !accum_active_o)
        else $error("result not offered after stop");
    AST_FAST_MEAS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (test_mode_o && $past(test_mode_o)) |-> s_ff.meas_cnt < CW'(TEST_MEAS_CYC))
        else $error("test measuring period too long");
    AST_SILENT_LOW: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (sec_tick && avg_cnt == 8'h00) |=> !pulse_o [*3])
        else $error("pulse emitted below cut-off");
    AST_GROUP_START: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (sec_tick && avg_cnt != 8'h00 && !stop_edge) |=> pulse_o && s_ff.pulses_left == $past(avg_cnt))
        else $error("group not started at interval");
    AST_START_WINDOW: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        start_edge |=> accum_active_o && !accum_ready_o && s_ff.acc == '0 ##1 accum_active_o)
        else $error("start edge did not open window");

endmodule

//--- verif/flow_source.sv
// flow source and test-control pin of the calibration rig
module flow_source #(
    parameter int VW = 24
) (
    input  wire logic                 clk_i,
    input  wire logic                 reset_n_i,
    input  wire logic                 strobe_i,
    input  wire logic signed [VW-1:0] vol_i,
    input  wire logic                 ground_i,
    output logic signed [VW-1:0]      meas_volume_o,
    output logic                      test_ctl_n_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // volume valid only in the strobe cycle; inverted elsewhere so stale use shows
    assign meas_volume_o = strobe_i ? vol_i : ~vol_i;
    // pin is grounded at power-up for the strap, and for the test window
    // no serial traffic is modelled, so none happens in a test or before 2 s
    assign test_ctl_n_o = ~ground_i;
endmodule

//--- verif/flow_pulse_test_control_bench.sv
// self-checking bench for the flow pulse and test control block
module flow_pulse_test_control_bench;
    timeunit 1ns;
    timeprecision 1ns;

    // --------------------------------------------------------------
    // shortened timing keeps the run near 62k cycles
    // --------------------------------------------------------------
    localparam int E  = 2000;
    localparam int M  = 500;
    localparam int PW = 6;
    localparam int PS = 40;

    logic               clk = 1'b0;
    logic               reset_n = 1'b0;
    logic               ground = 1'b1;
    logic signed [23:0] vol = 24'sh001f40;
    logic signed [23:0] meas_vol;
    logic signed [31:0] acc;
    logic               pin_n, strobe, pulse, tmode, active, ready;
    int                 mismatches, checked, cyc, rises, pauses, bad_width;
    int                 hi_run, lo_run, last_strobe, strobe_gap, sec_n, sec_p, sec_w;

    always #10 clk = ~clk;

    flow_pulse_test_control #(.EMIT_CYC(E), .PULSE_CYC(PW), .PAUSE_CYC(PS), .MEAS_CYC(M),
        .TEST_MEAS_CYC(M / 4), .GAP_SLOW_CYC(40), .GAP_MID_CYC(20), .GAP_FAST_CYC(8),
        .GAP_MAX_CYC(2)) i_flow_pulse_test_control (
        .clk_i(clk), .reset_n_i(reset_n), .test_ctl_n_i(pin_n), .meas_volume_i(meas_vol),
        .meas_strobe_o(strobe), .pulse_o(pulse), .test_mode_o(tmode),
        .accum_active_o(active), .accum_ready_o(ready), .accum_volume_o(acc));

    flow_source #(.VW(24)) i_flow_source (
        .clk_i(clk), .reset_n_i(reset_n), .strobe_i(strobe), .vol_i(vol),
        .ground_i(ground), .meas_volume_o(meas_vol), .test_ctl_n_o(pin_n));

    // --------------------------------------------------------------
    // monitor: cycle count, strobe spacing, pulse widths and pauses
    // --------------------------------------------------------------
    always @(posedge clk) begin
        if (!reset_n) begin
            cyc <= 0;
            last_strobe <= 0;
        end else begin
            cyc <= cyc + 1;
            if (strobe === 1'b1) begin
                strobe_gap <= cyc - last_strobe;
                last_strobe <= cyc;
            end
        end
        if (pulse === 1'b1) begin
            hi_run <= hi_run + 1;
            lo_run <= 0;
            if (lo_run > 0) rises <= rises + 1;
            if (lo_run == PS) pauses <= pauses + 1;
        end else begin
            lo_run <= lo_run + 1;
            hi_run <= 0;
            if (hi_run > 0 && hi_run != PW) bad_width <= bad_width + 1;
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // window opens just before a tick so one whole group falls inside it
    task automatic count_sec();
        int r0, p0, w0;
        do @(posedge clk); while (cyc % E != E - 20);
        r0 = rises;
        p0 = pauses;
        w0 = bad_width;
        repeat (E) @(posedge clk);
        sec_n = rises - r0;
        sec_p = pauses - p0;
        sec_w = bad_width - w0;
    endtask

    task automatic power_up(input logic strap, input logic signed [23:0] v);
        reset_n <= 1'b0;
        ground <= strap;
        vol <= v;
        repeat (2) @(posedge clk);
        chk("mode in reset", 32'(tmode), 32'h0);
        chk("pulse in reset", 32'(pulse), 32'h0);
        chk("result in reset", acc, 32'h0);
        reset_n <= 1'b1;
    endtask

    task automatic t_entry();
        repeat (100) @(posedge clk);
        ground <= 1'b0;
        repeat (E - 110) @(posedge clk);
        chk("mode early", 32'(tmode), 32'h0);
        repeat (20) @(posedge clk);
        chk("mode entered", 32'(tmode), 32'h1);
        repeat (300) @(posedge clk);
        chk("test period", 32'(strobe_gap), 32'(M / 4));
    endtask

    // 16 strobes of 8000 a second averages far past the cap
    task automatic t_cap();
        repeat (3 * E) @(posedge clk);
        count_sec();
        chk("capped count", 32'(sec_n), 32'h80);
        chk("burst pauses", 32'(sec_p), 32'h7);
        chk("pulse width", 32'(sec_w), 32'h0);
    endtask

    // 8000 over 125 cycles is 64 per cycle, so the result is 64 per window cycle
    task automatic t_window();
        int f, s, r0;
        logic signed [31:0] d;
        do @(posedge clk); while (cyc % E != 10);
        ground <= 1'b1;
        f = cyc;
        @(posedge clk);
        chk("sync delay", 32'(active), 32'h0);
        repeat (6) @(posedge clk);
        chk("window open", 32'(active), 32'h1);
        chk("result cleared", 32'(ready), 32'h0);
        repeat (E + 290) @(posedge clk);
        ground <= 1'b0;
        s = cyc;
        r0 = rises;
        repeat (6) @(posedge clk);
        d = acc - 32'(64 * (s - f));
        chk("window closed", 32'(active), 32'h0);
        chk("result ready", 32'(ready), 32'h1);
        chk("volume", 32'(d >= -64 && d <= 64), 32'h1);
        do @(posedge clk); while (cyc % E != E - 20);
        chk("emission stopped", 32'(rises - r0), 32'h0);
        chk("mode kept", 32'(tmode), 32'h1);
    endtask

    task automatic t_normal();
        repeat (E) @(posedge clk);
        chk("normal period", 32'(strobe_gap), 32'(M));
        ground <= 1'b1;
        repeat (50) @(posedge clk);
        chk("pin ignored", 32'(active), 32'h0);
        ground <= 1'b0;
        repeat (2 * E) @(posedge clk);
        chk("stays normal", 32'(tmode), 32'h0);
    endtask

    // four strobes of 640 a second is 10 pulses once the history is full
    task automatic t_steady();
        repeat (8 * E) @(posedge clk);
        count_sec();
        chk("steady count", 32'(sec_n), 32'ha);
        chk("normal width", 32'(sec_w), 32'h0);
    endtask

    task automatic t_tail();
        vol <= -24'sh000280;
        count_sec();
        chk("tail present", 32'(sec_n > 0), 32'h1);
        repeat (6 * E) @(posedge clk);
        count_sec();
        chk("tail over", 32'(sec_n), 32'h0);
    endtask

    // hang guard: the sequence needs about 62k cycles
    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        wrap_up();
    end

    initial begin
        power_up(1'b1, 24'sh001f40);
        t_entry();
        t_cap();
        t_window();
        power_up(1'b0, 24'sh000280);
        t_normal();
        t_steady();
        t_tail();
        wrap_up();
    end
endmodule
